/* hdl/icc_counter.sv */
// Free-running capture time base counter with tick enable.
`timescale 1ns/100ps
module icc_counter #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic tick,
  output logic [W-1:0] count
);
  import icc_pkg::*;

  logic [W-1:0] next_count;

  initial begin
    if (W < 2) $error("icc_counter width must be at least two");
  end

  always_comb begin
    next_count = count;
    if (!run) next_count = '0;
    else if (tick) next_count = count + W'(1);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) count <= '0;
    else count <= next_count;
  end
endmodule // icc_counter

/* hdl/icc_sync.sv */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
module icc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  import icc_pkg::*;

  logic [W-1:0] s1, s2, s3;
  logic [W-1:0] next_dout;

  initial begin
    if (W < 1) $error("icc_sync width must be at least one");
  end

  // The first stage feeds only the second, so metastability stays contained.
  always_comb begin
    next_dout = dout;
    for (int i = 0; i < W; i++) begin
      if (s2[i] == s3[i]) next_dout[i] = s3[i];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule // icc_sync

/* hdl/icc_top.sv */
// Input capture channel with its first control register and a capture FIFO.
//
// Summary of operation
// - With the idle-stop bit set the counter and captures halt while the CPU idles; mode 111 still interrupts.
// - Time base code 111 clocks the counter from the peripheral clock.
// - Code 100 takes the timer-1 clock, in its synchronous form only.
// - Code 011 takes the timer-5 clock as the counter's increment source.
// - Bits 6-5 set captures per interrupt, the top code meaning four.
// - The captures-per-interrupt field is ignored in modes 001 and 111.
// - Bits 15-14 and 9-7 are unimplemented, read zero, ignore writes.
// - Mode 000 switches the capture channel off.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module icc_top #(
  parameter int CNT_W = 16,
  parameter int DEPTH = icc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [icc_pkg::ADDR_W-1:0] addr,
  input wire logic [icc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [icc_pkg::DATA_W-1:0] rdata,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic timer1_clock,
  input wire logic [3:0] timer_clocks,
  input wire logic capture_pin,
  output logic irq
);
  import icc_pkg::*;

  initial begin
    if (DEPTH != 4) $error("icc_top supports a FIFO depth of four only");
    if (CNT_W != DATA_W) $error("icc_top counter must match data width");
  end

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic ctl_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
    ctl_hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // timer_clocks: 0 timer2, 1 timer3, 2 timer4, 3 timer5.
  logic [5:0] raw_in, sync_in;
  assign raw_in = {capture_pin, timer1_clock, timer_clocks};

  icc_sync #(.W(6)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(raw_in),
    .dout(sync_in)
  );

  logic [5:0] sync_d;
  logic pin_now, pin_prev;
  assign pin_now = sync_in[5];
  assign pin_prev = sync_d[5];

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  logic [15:0] ctrl, next_ctrl;
  logic [ST_W-1:0] stat, next_stat, mask, next_mask;
  logic idle_stop_ctl;
  logic [2:0] capture_timebase_sel, capture_mode_sel;
  logic [1:0] captures_per_irq_sel;
  logic capture_overflow_flag, buffer_not_empty_flag;

  assign idle_stop_ctl = ctrl[BIT_IDLE_STOP];
  assign capture_timebase_sel = ctrl[TSEL_MSB:TSEL_LSB];
  assign captures_per_irq_sel = ctrl[IRQSEL_MSB:IRQSEL_LSB];
  assign capture_mode_sel = ctrl[MODE_MSB:MODE_LSB];

  // ----------------------------------------------------------------------
  // Time base selection
  // ----------------------------------------------------------------------
  logic tb_tick, halted, chan_on;
  logic [DATA_W-1:0] tb_count;

  always_comb begin
    case (icc_tsel_e'(capture_timebase_sel))
      TB_PERIPH: tb_tick = 1'b1;
      TB_TMR1: tb_tick = sync_in[4] & ~sync_d[4];
      TB_TMR5: tb_tick = sync_in[3] & ~sync_d[3];
      TB_TMR4: tb_tick = sync_in[2] & ~sync_d[2];
      TB_TMR3: tb_tick = sync_in[1] & ~sync_d[1];
      TB_TMR2: tb_tick = sync_in[0] & ~sync_d[0];
      default: tb_tick = 1'b0; // Reserved codes hold the counter.
    endcase
  end

  assign chan_on = (capture_mode_sel != MD_OFF);
  assign halted = idle_stop_ctl & cpu_idle;

  icc_counter #(.W(DATA_W)) u_cnt (
    .clk(clk),
    .arst_n(arst_n),
    .run(chan_on),
    .tick(tb_tick & ~halted),
    .count(tb_count)
  );

  // ----------------------------------------------------------------------
  // Edge qualification
  // ----------------------------------------------------------------------
  logic rise, fall, edge_hit;
  logic [3:0] pre_cnt, next_pre_cnt;
  assign rise = pin_now & ~pin_prev;
  assign fall = ~pin_now & pin_prev;

  // Prescaled modes count rising edges; the counter clears on every control write.
  always_comb begin
    next_pre_cnt = pre_cnt;
    edge_hit = 1'b0;
    if (chan_on && !halted) begin
      case (icc_mode_e'(capture_mode_sel))
        MD_BOTH: edge_hit = rise | fall;
        MD_FALL: edge_hit = fall;
        MD_RISE: edge_hit = rise;
        MD_RISE4: begin
          if (rise) next_pre_cnt = pre_cnt + 4'h1;
          edge_hit = rise & (pre_cnt[1:0] == 2'h3);
        end
        MD_RISE16: begin
          if (rise) next_pre_cnt = pre_cnt + 4'h1;
          edge_hit = rise & (pre_cnt == 4'hF);
        end
        default: edge_hit = 1'b0;
      endcase
    end
    if (wr && ctl_hit(addr, OFS_CTRL)) next_pre_cnt = 4'h0;
  end

  // Interrupt-only mode raises an interrupt on a rising edge, even idle.
  logic int_mode_evt;
  assign int_mode_evt = (capture_mode_sel == MD_INT) & rise;

  // ----------------------------------------------------------------------
  // Capture FIFO
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] fifo [DEPTH];
  logic [1:0] wp, rp, next_wp, next_rp;
  logic [2:0] lvl, next_lvl;
  logic do_push, do_pop, ovf, next_ovf;
  logic [1:0] cap_cnt, next_cap_cnt;
  logic cap_irq;

  assign do_pop = rd && ctl_hit(addr, OFS_CAPT) && (lvl != 3'h0);
  // A full FIFO drops new captures and flags overflow.
  assign do_push = edge_hit && (lvl != 3'(DEPTH));

  always_comb begin
    next_wp = do_push ? wp + 2'h1 : wp;
    next_rp = do_pop ? rp + 2'h1 : rp;
    next_lvl = lvl + (do_push ? 3'h1 : 3'h0) - (do_pop ? 3'h1 : 3'h0);
    next_ovf = ovf;
    if (edge_hit && !do_push) next_ovf = 1'b1;
    else if (!chan_on) next_ovf = 1'b0;
    next_cap_cnt = cap_cnt;
    cap_irq = 1'b0;
    if (!chan_on) next_cap_cnt = 2'h0;
    else if (edge_hit) begin
      if (capture_mode_sel == MD_BOTH) cap_irq = 1'b1;
      else if (cap_cnt == captures_per_irq_sel) begin
        cap_irq = 1'b1;
        next_cap_cnt = 2'h0;
      end else next_cap_cnt = cap_cnt + 2'h1;
    end
  end

  assign capture_overflow_flag = ovf;
  assign buffer_not_empty_flag = (lvl != 3'h0);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp <= '0;
      rp <= '0;
      lvl <= '0;
      ovf <= 1'b0;
      cap_cnt <= '0;
      pre_cnt <= '0;
      sync_d <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      lvl <= next_lvl;
      ovf <= next_ovf;
      cap_cnt <= next_cap_cnt;
      pre_cnt <= next_pre_cnt;
      sync_d <= sync_in;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) fifo[wp] <= tb_count;
  end

  // ----------------------------------------------------------------------
  // Register writes and interrupt status
  // ----------------------------------------------------------------------
  logic ovf_rise;
  assign ovf_rise = next_ovf & ~ovf;

  always_comb begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_stat = stat;
    if (wr && ctl_hit(addr, OFS_CTRL))
      next_ctrl = wdata & CTRL_WMASK;
    if (wr && ctl_hit(addr, OFS_MASK)) next_mask = wdata[ST_W-1:0];
    if (wr && ctl_hit(addr, OFS_STAT))
      next_stat = stat & ~wdata[ST_W-1:0];
    // Setting wins over a clear in the same cycle.
    if (cap_irq || int_mode_evt) next_stat[ST_IRQ] = 1'b1;
    if (ovf_rise) next_stat[ST_OVF] = 1'b1;
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;
  logic next_irq;

  always_comb begin
    next_rdata = '0;
    if (rd) begin
      case (addr)
        OFS_CTRL: begin
          next_rdata = ctrl;
          next_rdata[BIT_OVF] = capture_overflow_flag;
          next_rdata[BIT_BNE] = buffer_not_empty_flag;
        end
        OFS_STAT: next_rdata = DATA_W'(stat);
        OFS_MASK: next_rdata = DATA_W'(mask);
        OFS_CAPT: next_rdata = (lvl != 3'h0) ? fifo[rp] : '0;
        default: next_rdata = '0;
      endcase
    end
    next_irq = |(next_stat & next_mask);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= CTRL_RESET;
      mask <= '0;
      stat <= '0;
      rdata <= '0;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      mask <= next_mask;
      stat <= next_stat;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_ctrl_wr;
    wr && ctl_hit(addr, OFS_CTRL);
  endsequence

  // A control write may switch the channel off or retarget the counter, so
  // the idle, peripheral and timer counter checks leave that cycle out.
  logic ctrl_wr;
  assign ctrl_wr = wr && ctl_hit(addr, OFS_CTRL);

  a_unimpl_zero: assert property (@(posedge clk) disable iff (!arst_n)
    (ctrl & ~CTRL_WMASK) == 16'h0000)
    else $error("unimplemented control bits not zero");
  a_ctrl_write: assert property (@(posedge clk) disable iff (!arst_n)
    s_ctrl_wr |=> ctrl == ($past(wdata) & CTRL_WMASK))
    else $error("control write not stored");
  a_off_no_count: assert property (@(posedge clk) disable iff (!arst_n)
    !chan_on ##1 !chan_on |-> tb_count == '0)
    else $error("counter runs while channel off");
  a_idle_halt: assert property (@(posedge clk) disable iff (!arst_n)
    halted && chan_on && !ctrl_wr |=> tb_count == $past(tb_count))
    else $error("counter moved during idle halt");
  a_periph_tick: assert property (@(posedge clk) disable iff (!arst_n)
    chan_on && !halted && capture_timebase_sel == TB_PERIPH
    && !ctrl_wr |=> tb_count == $past(tb_count) + 16'h0001)
    else $error("peripheral clock did not step counter");
  a_tmr_ticks: assert property (@(posedge clk) disable iff (!arst_n)
    chan_on && !ctrl_wr && capture_timebase_sel == TB_TMR5
    && !(sync_in[3] & ~sync_d[3]) |=> tb_count == $past(tb_count))
    else $error("timer5 base ticked without edge");
  a_tmr1_ticks: assert property (@(posedge clk) disable iff (!arst_n)
    chan_on && !halted && !ctrl_wr && capture_timebase_sel == TB_TMR1
    && (sync_in[4] & ~sync_d[4])
    |=> tb_count == $past(tb_count) + 16'h0001)
    else $error("timer1 base did not step counter");
  a_every_irq: assert property (@(posedge clk) disable iff (!arst_n)
    edge_hit && capture_mode_sel == MD_BOTH |=> stat[ST_IRQ])
    else $error("both-edge mode missed interrupt");
  a_irq_count: assert property (@(posedge clk) disable iff (!arst_n)
    edge_hit && capture_mode_sel != MD_BOTH
    && cap_cnt != captures_per_irq_sel |-> !cap_irq)
    else $error("interrupt raised too early");
  a_bne_flag: assert property (@(posedge clk) disable iff (!arst_n)
    rd && addr == OFS_CTRL |=> rdata[BIT_BNE] == $past(lvl != 3'h0))
    else $error("buffer flag read mismatch");
endmodule // icc_top

/* inc/icc_pkg.sv */
// Package of constants and types for the input capture control block.
package icc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CAPT = 4'hC;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int BIT_IDLE_STOP = 13;
  localparam int TSEL_LSB = 10;
  localparam int TSEL_MSB = 12;
  localparam int IRQSEL_LSB = 5;
  localparam int IRQSEL_MSB = 6;
  localparam int BIT_OVF = 4;
  localparam int BIT_BNE = 3;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam logic [15:0] CTRL_WMASK = 16'h3C67;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Status bits
  // ----------------------------------------------------------------------
  localparam int ST_W = 2;
  localparam int ST_IRQ = 0;
  localparam int ST_OVF = 1;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    TB_TMR3 = 3'b000,
    TB_TMR2 = 3'b001,
    TB_TMR4 = 3'b010,
    TB_TMR5 = 3'b011,
    TB_TMR1 = 3'b100,
    TB_RSV5 = 3'b101,
    TB_RSV6 = 3'b110,
    TB_PERIPH = 3'b111
  } icc_tsel_e;

  typedef enum logic [2:0] {
    MD_OFF = 3'b000,
    MD_BOTH = 3'b001,
    MD_FALL = 3'b010,
    MD_RISE = 3'b011,
    MD_RISE4 = 3'b100,
    MD_RISE16 = 3'b101,
    MD_RSV = 3'b110,
    MD_INT = 3'b111
  } icc_mode_e;

  localparam int FIFO_DEPTH = 4;
  localparam int SYNC_STAGES = 3;

endpackage

/* sim/icc_edge_src.sv */
// Model of the external edge source that drives the capture input pin.
`timescale 1ns/100ps
module icc_edge_src #(
  parameter int HIGH_CYC = 6
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic fire,
  output logic pin
);
  int cnt;

  // ----------------------------------------------------------------------
  // Pulse generator
  // ----------------------------------------------------------------------
  // Each request gives one rising and one falling edge; the high time is
  // long enough for the synchroniser to agree on both levels.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin <= 1'b0;
      cnt <= 0;
    end else if (fire) begin
      pin <= 1'b1;
      cnt <= HIGH_CYC;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      pin <= 1'b0;
      cnt <= 0;
    end
  end
endmodule // icc_edge_src

/* sim/input_capture_control_one_bench.sv */
// Self-checking testbench of the input capture control block.
`timescale 1ns/100ps
module input_capture_control_one_bench;
  import icc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic cpu_idle = 1'b0;
  logic tmr1 = 1'b0;
  logic [3:0] tmrs = 4'h0;
  logic fire = 1'b0;
  logic pin;
  logic irq;
  int n_fail = 0;
  int n_checks = 0;

  always #2 clk = ~clk;

  icc_top u_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cpu_idle(cpu_idle),
    .cpu_sleep(1'b0), .timer1_clock(tmr1), .timer_clocks(tmrs),
    .capture_pin(pin), .irq(irq));

  icc_edge_src u_src (.clk(clk), .arst_n(arst_n), .fire(fire), .pin(pin));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic end_sim();
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd_reg(a, d);
    check(d, e);
  endtask

  // One pin pulse, then time for synchroniser, push and status to land.
  task automatic pulse(input int settle);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (settle) @(posedge clk);
  endtask

  task automatic tpulse(input int src);
    repeat (2) begin
      @(posedge clk);
      if (src == 1) tmr1 <= ~tmr1;
      if (src == 2) tmrs[3] <= ~tmrs[3];
      repeat (3) @(posedge clk);
    end
  endtask

  // The interrupt is looked at off the clock edge, once it has settled.
  task automatic wait_irq(input logic lvl);
    int i;
    #1;
    for (i = 0; i < 20 && irq !== lvl; i++) begin
      @(posedge clk);
      #1;
    end
    check({15'h0, irq}, {15'h0, lvl});
    if (irq !== lvl) end_sim();
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_and_fields();
    rd_chk(OFS_CTRL, 16'h0000);
    rd_chk(OFS_STAT, 16'h0000);
    wr_reg(OFS_CTRL, 16'hFFFF);
    rd_chk(OFS_CTRL, 16'h3C67);
    wr_reg(OFS_CTRL, 16'h0000);
    rd_chk(OFS_CTRL, 16'h0000);
  endtask

  task automatic t_one_capture_irq();
    logic [15:0] d;
    wr_reg(OFS_MASK, 16'h0001);
    wr_reg(OFS_CTRL, 16'h1C03);
    pulse(10);
    rd_chk(OFS_CTRL, 16'h1C0B);
    wr_reg(OFS_CTRL, 16'h1C1B);
    rd_chk(OFS_CTRL, 16'h1C0B);
    rd_chk(OFS_STAT, 16'h0001);
    wait_irq(1'b1);
    wr_reg(OFS_STAT, 16'h0001);
    wait_irq(1'b0);
    rd_chk(OFS_CTRL, 16'h1C0B);
    rd_reg(OFS_CAPT, d);
    rd_chk(OFS_CTRL, 16'h1C03);
  endtask

  task automatic t_four_per_irq_overflow();
    logic [15:0] d;
    wr_reg(OFS_CTRL, 16'h1C63);
    repeat (3) pulse(10);
    rd_chk(OFS_STAT, 16'h0000);
    pulse(10);
    rd_chk(OFS_STAT, 16'h0001);
    pulse(10);
    rd_chk(OFS_CTRL, 16'h1C7B);
    repeat (4) rd_reg(OFS_CAPT, d);
    wr_reg(OFS_STAT, 16'h0003);
    wr_reg(OFS_CTRL, 16'h0000);
    rd_chk(OFS_CTRL, 16'h0000);
    pulse(10);
    rd_chk(OFS_CTRL, 16'h0000);
    rd_chk(OFS_STAT, 16'h0000);
  endtask

  task automatic t_ignored_irq_field();
    logic [15:0] d;
    wr_reg(OFS_CTRL, 16'h1C61);
    pulse(14);
    rd_chk(OFS_STAT, 16'h0001);
    repeat (2) rd_reg(OFS_CAPT, d);
    wr_reg(OFS_STAT, 16'h0001);
    wr_reg(OFS_CTRL, 16'h1C67);
    pulse(10);
    rd_chk(OFS_STAT, 16'h0001);
    rd_chk(OFS_CTRL, 16'h1C67);
    wr_reg(OFS_STAT, 16'h0001);
  endtask

  task automatic t_idle(input logic stop, input logic [15:0] e);
    logic [15:0] d;
    wr_reg(OFS_CTRL, {2'b00, stop, 13'h1C03});
    cpu_idle <= 1'b1;
    pulse(10);
    rd_chk(OFS_CTRL, e);
    cpu_idle <= 1'b0;
    if (e[BIT_BNE]) rd_reg(OFS_CAPT, d);
    wr_reg(OFS_STAT, 16'h0001);
  endtask

  // Difference of two capture stamps taken 42 cycles apart.
  task automatic t_timebase(input logic [2:0] ts, input int src,
                            input logic [15:0] e);
    logic [15:0] d0;
    logic [15:0] d1;
    wr_reg(OFS_CTRL, {3'b000, ts, 10'h003});
    pulse(0);
    repeat (3) tpulse(src);
    repeat (16) @(posedge clk);
    pulse(10);
    rd_reg(OFS_CAPT, d0);
    rd_reg(OFS_CAPT, d1);
    check(d1 - d0, e);
    wr_reg(OFS_STAT, 16'h0001);
  endtask

  // Every fourth and every sixteenth rising edge, then falling edges only.
  task automatic t_prescale_modes();
    logic [15:0] d;
    wr_reg(OFS_CTRL, 16'h1C04);
    repeat (3) pulse(10);
    rd_chk(OFS_CTRL, 16'h1C04);
    pulse(10);
    rd_chk(OFS_CTRL, 16'h1C0C);
    rd_chk(OFS_STAT, 16'h0001);
    rd_reg(OFS_CAPT, d);
    wr_reg(OFS_STAT, 16'h0001);
    wr_reg(OFS_CTRL, 16'h1C05);
    repeat (15) pulse(10);
    rd_chk(OFS_STAT, 16'h0000);
    pulse(10);
    rd_chk(OFS_CTRL, 16'h1C0D);
    rd_chk(OFS_STAT, 16'h0001);
    rd_reg(OFS_CAPT, d);
    wr_reg(OFS_STAT, 16'h0001);
    wr_reg(OFS_CTRL, 16'h1C02);
    pulse(14);
    rd_chk(OFS_CTRL, 16'h1C0A);
    rd_chk(OFS_STAT, 16'h0001);
    rd_reg(OFS_CAPT, d);
    wr_reg(OFS_STAT, 16'h0001);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset_and_fields();
    t_one_capture_irq();
    t_four_per_irq_overflow();
    t_ignored_irq_field();
    t_idle(1'b1, 16'h3C03);
    t_idle(1'b0, 16'h1C0B);
    t_timebase(3'b111, 0, 16'h002A);
    t_timebase(3'b100, 1, 16'h0003);
    t_timebase(3'b100, 0, 16'h0000);
    t_timebase(3'b011, 2, 16'h0003);
    t_timebase(3'b011, 1, 16'h0000);
    t_prescale_modes();
    end_sim();
  end
endmodule // input_capture_control_one_bench
